// ### dv/qdsc_link_checker.sv
// Wire-level checks on the serial link between controller and driver.
// Assumes the link signals and sys_clk/rst of the bench, no bind.
module qdsc_link_checker (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic select_n,
   input wire logic serialClk,
   input wire logic serialIn,
   input wire logic serialOut,
   input wire logic serialOutOe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic prevClk;
   logic [4:0] riseCnt;
   logic [7:0] inHist;
   always_ff @(posedge sys_clk) begin
      prevClk <= serialClk;
      if (rst || select_n) begin
         riseCnt <= 5'h00;
      end else if (serialClk && !prevClk) begin
         riseCnt <= riseCnt + 5'h01;
      end
      if (serialClk && !prevClk) begin
         inHist <= {inHist[6:0], serialIn};
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence clkHighHold;
      serialClk [*2];
   endsequence
   sequence clkLowHold;
      !serialClk [*2];
   endsequence
   sequence setupQuiet;
      !serialClk [*8];
   endsequence
   a_oe_off_idle: assert property (select_n [*6] |-> !serialOutOe) else $error("output driven while deselected");
   a_oe_on_select: assert property ($fell(select_n) |-> ##[1:6] serialOutOe) else $error("output not enabled");
   a_clk_idle_low: assert property (select_n |-> !serialClk) else $error("serial clock active while idle");
   a_clk_high_min: assert property ($rose(serialClk) |-> clkHighHold) else $error("clock high too short");
   a_clk_low_min: assert property ($fell(serialClk) |-> clkLowHold) else $error("clock low too short");
   a_select_setup: assert property ($fell(select_n) |-> setupQuiet) else $error("clock too soon after select");
   a_in_stable_rise: assert property ($rose(serialClk) |-> $stable(serialIn)) else $error("input moved at rise");
   a_out_high_stable: assert property (serialClk && $past(serialClk) |-> $stable(serialOut)) else $error("out moved");
   a_upper_status_zero: assert property ($rose(serialClk) && riseCnt < 5'h04 |-> serialOutOe && !serialOut)
      else $error("upper status bit not zero");
   a_echo_bits: assert property ($rose(serialClk) && riseCnt >= 5'h08 |-> serialOut == inHist[7])
      else $error("echo bit mismatch");
endmodule

// ### dv/testbench.sv
// Self-checking bench: controller bus tasks drive frames into the driver.
// Assumes both design ends share sys_clk and one link interface.
module testbench;
   import qdsc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avAddress = 4'h0;
   logic avRead = 1'b0;
   logic avWrite = 1'b0;
   logic [31:0] avWritedata = 32'h0000_0000;
   logic [31:0] avReaddata;
   logic avWaitrequest;
   logic [3:0] parIn = 4'h0;
   logic ovIndication = 1'b0;
   logic [3:0] ocIndication = 4'h0;
   logic [3:0] olIndication = 4'h0;
   logic [3:0] drv;
   logic [31:0] drvWord;
   logic statusOe;
   logic [31:0] rd;
   int n_errors = 0;
   int checked = 0;
   int ones;
   assign drvWord = {28'h000_0000, drv};
   always #50 sys_clk = ~sys_clk;
   qdsc_link_if qdsc_link_if_i ();
   qdsc_host qdsc_host_i (.sys_clk(sys_clk), .rst(rst), .link(qdsc_link_if_i), .avAddress(avAddress),
      .avRead(avRead), .avWrite(avWrite), .avWritedata(avWritedata), .avReaddata(avReaddata),
      .avWaitrequest(avWaitrequest));
   qdsc_device qdsc_device_i (.sys_clk(sys_clk), .rst(rst), .link(qdsc_link_if_i), .par_in_0(parIn[0]),
      .par_in_1(parIn[1]), .par_in_2(parIn[2]), .par_in_3(parIn[3]), .ovIndication(ovIndication),
      .ocIndication(ocIndication), .olIndication(olIndication), .drv_out_0(drv[0]), .drv_out_1(drv[1]),
      .drv_out_2(drv[2]), .drv_out_3(drv[3]), .statusOut(), .statusOe(statusOe));
   qdsc_link_checker qdsc_link_checker_i (.sys_clk(sys_clk), .rst(rst), .select_n(qdsc_link_if_i.select_n),
      .serialClk(qdsc_link_if_i.serialClk), .serialIn(qdsc_link_if_i.serialIn),
      .serialOut(qdsc_link_if_i.serialOut), .serialOutOe(qdsc_link_if_i.serialOutOe));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // Request stands until waitrequest is seen low at a rising edge; data taken there
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      avAddress <= a;
      avWritedata <= wd;
      avWrite <= wr;
      avRead <= ~wr;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avWaitrequest !== 1'b0 && n < 50);
      rd = avReaddata;
      avRead <= 1'b0;
      avWrite <= 1'b0;
      @(posedge sys_clk);
      if (n >= 50) begin
         chk(32'h0000_0001, 32'h0000_0000, "bus hang");
      end
   endtask
   task automatic frame(input logic lng, input logic [15:0] tx);
      int n;
      n = 0;
      bus(1'b1, REG_TXDATA, {16'h0000, tx});
      bus(1'b1, REG_CTRL, {30'h0000_0000, lng, 1'b1});
      do begin
         bus(1'b0, REG_STATUS, 32'h0000_0000);
         n++;
      end while (rd[STAT_BUSY] !== 1'b0 && n < 400);
      chk(32'(n < 400), 32'h0000_0001, "frame end");
      bus(1'b0, REG_RXDATA, 32'h0000_0000);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      frame(1'b0, 16'h00C5);
      chk(rd, 32'h0000_0000, "short status");
      chk(drvWord, 32'h0000_0005, "short drivers");
      $display("test done: short frame");
      for (int i = 0; i < 4; i++) begin
         parIn <= 4'(1 << i);
         repeat (10) @(posedge sys_clk);
         chk(drvWord, {28'h000_0000, 4'h5 | 4'(1 << i)}, "parallel or");
         ovIndication <= 1'b1;
         repeat (10) @(posedge sys_clk);
         chk(drvWord, 32'h0000_0000, "overvoltage");
         ovIndication <= 1'b0;
         repeat (10) @(posedge sys_clk);
         chk(drvWord, {28'h000_0000, 4'h5 | 4'(1 << i)}, "recovery");
      end
      parIn <= 4'h0;
      $display("test done: parallel and overvoltage");
      frame(1'b1, 16'hA50A);
      chk(rd, 32'h0000_00A5, "long echo");
      bus(1'b0, REG_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "verify flag");
      chk(drvWord, 32'h0000_000A, "long drivers");
      frame(1'b1, 16'h3C03);
      chk(rd, 32'h0000_003C, "second echo");
      chk(drvWord, 32'h0000_0003, "second drivers");
      $display("test done: long frames");
      ocIndication <= 4'h2;
      repeat (700) @(posedge sys_clk);
      chk(32'(statusOe), 32'h0000_0001, "fault line oc");
      ones = 0;
      repeat (128) begin
         @(posedge sys_clk);
         if (drv[1] === 1'b1) ones++;
      end
      chk(32'(ones), 32'h0000_0002, "low duty");
      ocIndication <= 4'h0;
      repeat (20) @(posedge sys_clk);
      chk(32'(statusOe), 32'h0000_0001, "oc held");
      frame(1'b0, 16'h0000);
      chk(rd, 32'h0000_3C02, "oc status");
      chk(32'(statusOe), 32'h0000_0000, "oc cleared");
      $display("test done: overcurrent");
      olIndication <= 4'h1;
      repeat (700) @(posedge sys_clk);
      chk(32'(statusOe), 32'h0000_0001, "fault line ol");
      olIndication <= 4'h0;
      repeat (20) @(posedge sys_clk);
      frame(1'b0, 16'h0000);
      chk(rd, 32'h0000_0201, "ol status");
      chk(32'(statusOe), 32'h0000_0000, "ol cleared");
      $display("test done: open load");
      report_and_stop();
   end
   initial begin
      repeat (40000) @(posedge sys_clk);
      n_errors++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      report_and_stop();
   end
endmodule

// ### rtl/qdsc_device.sv
// Driver end: serial command port, four output drivers and fault logic.
// Assumes link pins and fault indications are asynchronous to sys_clk.
//
// What this block does
// - Select fall loads latched faults into shifter
// - Normal frame: eight bits in, four commands kept, faults out
// - Select rise applies last four bits
// - Long frame echoes earlier shifted bits
// - MSB first, input sampled on clock rise
// - Output changes on serial clock fall
// - Output released while select is high
// - Status bits 0-3 are channel faults
// - Serial clock ignored while deselected
// - Master keeps serial clock at most 4 MHz
// - Shifter passes data through for chaining
// - Driver on: serial bit OR parallel input
// - Overvoltage turns all outputs off
// - Persisting overcurrent sets channel fault bit
// - Overcurrent fault held until select rise
// - Overcurrent while on: low duty mode
// - Persisting open load while off sets fault
// - Fault line pulled low on any fault
// - Master checks echoed bits against command
module qdsc_device
   import qdsc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   qdsc_link_if.dev link,
   input wire logic par_in_0,
   input wire logic par_in_1,
   input wire logic par_in_2,
   input wire logic par_in_3,
   input wire logic ovIndication,
   input wire logic [NUM_CH-1:0] ocIndication,
   input wire logic [NUM_CH-1:0] olIndication,
   output logic drv_out_0,
   output logic drv_out_1,
   output logic drv_out_2,
   output logic drv_out_3,
   output logic statusOut,
   output logic statusOe
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [SYN_W-1:0] s1;
      logic [SYN_W-1:0] s2;
      logic [SYN_W-1:0] s3;
      logic [SYN_W-1:0] filt;
      logic [SYN_W-1:0] filtD;
      logic [SHIFT_W-1:0] shift;
      logic sdo;
      logic [NUM_CH-1:0] cmd;
      logic [NUM_CH-1:0] fault;
      logic [NUM_CH-1:0][CNT_W-1:0] ocCnt;
      logic [NUM_CH-1:0][CNT_W-1:0] olCnt;
      logic [DUTY_W-1:0] duty;
      logic [NUM_CH-1:0] drv;
   } qdsc_dev_st_t;

   qdsc_dev_st_t st;
   qdsc_dev_st_t next_st;

   logic [SYN_W-1:0] raw;
   logic selected;
   logic selFall;
   logic selRise;
   logic clkRise;
   logic clkFall;
   logic overVolt;
   logic dutyOn;
   logic [NUM_CH-1:0] want;
   logic [NUM_CH-1:0] ocCond;
   logic [NUM_CH-1:0] olCond;
   logic [NUM_CH-1:0] ocHit;
   logic [NUM_CH-1:0] olHit;
   logic [NUM_CH-1:0] drvNext;

   // ------------------------------------------------------------
   // Input gathering
   // ------------------------------------------------------------
   assign raw = {link.select_n, link.serialClk, link.serialIn,
                 par_in_3, par_in_2, par_in_1, par_in_0,
                 ovIndication, ocIndication, olIndication};

   // ------------------------------------------------------------
   // Edge detection on filtered pins
   // ------------------------------------------------------------
   assign selected = ~st.filt[SYN_SEL];
   assign selFall = st.filtD[SYN_SEL] & ~st.filt[SYN_SEL];
   assign selRise = ~st.filtD[SYN_SEL] & st.filt[SYN_SEL];
   // Clock edges only count while selected
   assign clkRise = selected & st.filt[SYN_CLK] & ~st.filtD[SYN_CLK];
   assign clkFall = selected & ~st.filt[SYN_CLK] & st.filtD[SYN_CLK];
   assign overVolt = st.filt[SYN_OV];
   assign dutyOn = st.duty < DUTY_ON_CYC;

   // ------------------------------------------------------------
   // Per channel drive and fault detection
   // ------------------------------------------------------------
   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
      assign want[ch] = st.cmd[ch] | st.filt[SYN_PAR + ch];
      assign ocCond[ch] = st.filt[SYN_OC + ch] & want[ch] & ~overVolt;
      assign olCond[ch] = st.filt[SYN_OL + ch] & ~want[ch];
      assign ocHit[ch] = ocCond[ch] & (st.ocCnt[ch] == SENSE_LAST);
      assign olHit[ch] = olCond[ch] & (st.olCnt[ch] == SENSE_LAST);
      // Overcurrent only chops the channel; overvoltage kills it outright
      assign drvNext[ch] = ~overVolt & want[ch] & (~st.filt[SYN_OC + ch] | dutyOn);
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_st = st;
      // ------------------------------------------------------------
      // Input filters
      // ------------------------------------------------------------
      next_st.s1 = raw;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      // A change counts once the second and third stages agree
      next_st.filt = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.filt);
      next_st.filtD = st.filt;
      next_st.duty = st.duty + 6'h01;

      // ------------------------------------------------------------
      // Shift register
      // ------------------------------------------------------------
      if (selFall) begin
         next_st.shift = {STATUS_UPPER, st.fault};
         next_st.sdo = STATUS_UPPER[3];
      end else if (clkRise) begin
         // Oldest bit leaves at the top, so chained parts see it next
         next_st.shift = {st.shift[SHIFT_W-2:0], st.filt[SYN_MOSI]};
      end
      if (clkFall) begin
         next_st.sdo = st.shift[SHIFT_W-1];
      end

      // ------------------------------------------------------------
      // Commands
      // ------------------------------------------------------------
      // Chained parts all take their low nibble at this same rise
      if (selRise) begin
         next_st.cmd = st.shift[NUM_CH-1:0];
      end

      // ------------------------------------------------------------
      // Sense counters
      // ------------------------------------------------------------
      for (int ch = 0; ch < NUM_CH; ch++) begin
         if (!ocCond[ch]) begin
            next_st.ocCnt[ch] = '0;
         end else if (st.ocCnt[ch] != SENSE_LAST) begin
            next_st.ocCnt[ch] = st.ocCnt[ch] + 10'h001;
         end
         if (!olCond[ch]) begin
            next_st.olCnt[ch] = '0;
         end else if (st.olCnt[ch] != SENSE_LAST) begin
            next_st.olCnt[ch] = st.olCnt[ch] + 10'h001;
         end
      end

      // ------------------------------------------------------------
      // Fault bits
      // ------------------------------------------------------------
      // A fault still present at select rise sets again at once
      next_st.fault = (selRise ? '0 : st.fault) | ocHit | olHit;
      next_st.drv = drvNext;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st <= '0;
         st.s1 <= SYN_RST;
         st.s2 <= SYN_RST;
         st.s3 <= SYN_RST;
         st.filt <= SYN_RST;
         st.filtD <= SYN_RST;
      end else begin
         st <= next_st;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign link.serialOut = st.sdo;
   assign link.serialOutOe = selected;
   assign drv_out_0 = st.drv[0];
   assign drv_out_1 = st.drv[1];
   assign drv_out_2 = st.drv[2];
   assign drv_out_3 = st.drv[3];

   // ------------------------------------------------------------
   // Fault line
   // ------------------------------------------------------------
   // Open drain: only ever pulls low
   assign statusOut = 1'b0;
   assign statusOe = |st.fault;

endmodule

// ### rtl/qdsc_host.sv
// Controller end: Avalon-MM slave registers and serial link master.
// Assumes one driver per select line and a software master on the bus.
module qdsc_host
   import qdsc_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   qdsc_link_if.host link,
   input wire logic [3:0] avAddress,
   input wire logic avRead,
   input wire logic avWrite,
   input wire logic [31:0] avWritedata,
   output logic [31:0] avReaddata,
   output logic avWaitrequest
);

   typedef struct packed {
      qdsc_hstate_t state;
      logic [7:0] cnt;
      logic [4:0] bitsLeft;
      logic [15:0] tx;
      logic [15:0] txShift;
      logic [15:0] rx;
      logic longFrame;
      logic busy;
      logic verr;
      logic ack;
      logic [31:0] rdata;
      logic selN;
      logic sclk;
      logic mosi;
      logic s1;
      logic s2;
      logic s3;
      logic filt;
   } qdsc_host_st_t;

   qdsc_host_st_t st;
   qdsc_host_st_t next_st;
   logic req;

   assign req = avRead | avWrite;

   always_comb begin
      next_st = st;
      next_st.s1 = link.serialOutLine;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
      next_st.filt = (st.s2 == st.s3) ? st.s3 : st.filt;

      // ------------------------------------------------------------
      // Bus slave: one wait state, write acts on the release edge
      // ------------------------------------------------------------
      next_st.ack = 1'b0;
      if (req && !st.ack) begin
         next_st.ack = 1'b1;
         case (avAddress)
            REG_CTRL: next_st.rdata = {30'h0000_0000, st.longFrame, 1'b0};
            REG_TXDATA: next_st.rdata = {16'h0000, st.tx};
            REG_RXDATA: next_st.rdata = {16'h0000, st.rx};
            REG_STATUS: next_st.rdata = {30'h0000_0000, st.verr, st.busy};
            default: next_st.rdata = 32'h0000_0000;
         endcase
      end else if (req && avWrite) begin
         if (avAddress == REG_TXDATA && !st.busy) begin
            next_st.tx = avWritedata[15:0];
         end
         if (avAddress == REG_STATUS && avWritedata[STAT_VERR]) begin
            next_st.verr = 1'b0;
         end
         if (avAddress == REG_CTRL && !st.busy) begin
            next_st.longFrame = avWritedata[CTRL_LONG];
            if (avWritedata[CTRL_START]) begin
               next_st.busy = 1'b1;
               next_st.state = H_SETUP;
               next_st.cnt = LINK_HALF_CYC;
               next_st.selN = 1'b0;
               next_st.bitsLeft = avWritedata[CTRL_LONG] ? 5'h10 : 5'h08;
               // Left align so the top bit always goes first
               next_st.txShift = avWritedata[CTRL_LONG] ? st.tx : {st.tx[7:0], 8'h00};
               next_st.mosi = next_st.txShift[15];
            end
         end
      end

      // ------------------------------------------------------------
      // Link sequencer
      // ------------------------------------------------------------
      if (st.state != H_IDLE) begin
         next_st.cnt = st.cnt - 8'h01;
      end
      case (st.state)
         H_IDLE: begin
         end
         H_SETUP, H_LOW: begin
            if (st.cnt == 8'h00) begin
               // Half period above the sync lag also keeps clock under 4 MHz
               next_st.sclk = 1'b1;
               next_st.rx = {st.rx[14:0], st.filt};
               next_st.bitsLeft = st.bitsLeft - 5'h01;
               next_st.cnt = LINK_HALF_CYC;
               next_st.state = H_HIGH;
            end
         end
         H_HIGH: begin
            if (st.cnt == 8'h00) begin
               next_st.sclk = 1'b0;
               next_st.cnt = LINK_HALF_CYC;
               if (st.bitsLeft == 5'h00) begin
                  next_st.state = H_HOLD;
               end else begin
                  next_st.txShift = {st.txShift[14:0], 1'b0};
                  next_st.mosi = st.txShift[14];
                  next_st.state = H_LOW;
               end
            end
         end
         H_HOLD: begin
            if (st.cnt == 8'h00) begin
               next_st.selN = 1'b1;
               next_st.cnt = LINK_XFER_CYC;
               next_st.state = H_GAP;
               if (st.longFrame && st.rx[7:0] != st.tx[15:8]) begin
                  next_st.verr = 1'b1;
               end
            end
         end
         H_GAP: begin
            if (st.cnt == 8'h00) begin
               next_st.busy = 1'b0;
               next_st.state = H_IDLE;
            end
         end
         default: begin
            next_st.state = H_IDLE;
            next_st.selN = 1'b1;
            next_st.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st <= '0;
         st.state <= H_IDLE;
         st.selN <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign avWaitrequest = req & ~st.ack;
   assign avReaddata = st.rdata;
   assign link.select_n = st.selN;
   assign link.serialClk = st.sclk;
   assign link.serialIn = st.mosi;

endmodule

// ### rtl/qdsc_link_if.sv
// Four-wire serial link between controller and driver.
// Assumes the bench connects one controller and one driver.
interface qdsc_link_if;
   logic select_n;
   logic serialClk;
   logic serialIn;
   logic serialOut;
   logic serialOutOe;
   logic serialOutLine;

   // No pull on this line: a released output reads low, never floats
   assign serialOutLine = serialOutOe & serialOut;

   modport dev (
      input select_n,
      input serialClk,
      input serialIn,
      output serialOut,
      output serialOutOe
   );

   modport host (
      output select_n,
      output serialClk,
      output serialIn,
      input serialOutLine
   );
endinterface

// ### rtl/qdsc_pkg.sv
// Shared constants and types for the quad driver serial control pair.
// Assumes a single 10 MHz system clock drives both ends.
package qdsc_pkg;

   // ------------------------------------------------------------
   // Clock and channel figures
   // ------------------------------------------------------------
   localparam int SYS_CLK_HZ = 10_000_000;
   localparam int NUM_CH = 4;
   localparam int SHIFT_W = 8;
   localparam int FRAME_LONG = 16;

   // ------------------------------------------------------------
   // Input synchroniser vector layout
   // ------------------------------------------------------------
   localparam int SYN_W = 16;
   localparam int SYN_SEL = 15;
   localparam int SYN_CLK = 14;
   localparam int SYN_MOSI = 13;
   localparam int SYN_PAR = 9;
   localparam int SYN_OV = 8;
   localparam int SYN_OC = 4;
   localparam int SYN_OL = 0;
   // Select idles high, everything else low
   localparam logic [SYN_W-1:0] SYN_RST = 16'h8000;

   // ------------------------------------------------------------
   // Fault timing
   // ------------------------------------------------------------
   localparam int SENSE_TIME_NS = 62500;
   localparam int SENSE_CYC = (SENSE_TIME_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CNT_W = 10;
   localparam logic [CNT_W-1:0] SENSE_LAST = CNT_W'(SENSE_CYC - 1);
   // One cycle on in 64 gives 1.5625 percent on-time
   localparam int DUTY_W = 6;
   localparam logic [DUTY_W-1:0] DUTY_ON_CYC = 6'h01;
   localparam logic [3:0] STATUS_UPPER = 4'h0;

   // ------------------------------------------------------------
   // Link timing made by the controller
   // ------------------------------------------------------------
   localparam int SCLK_MAX_HZ = 4_000_000;
   localparam int HALF_MIN_CYC = (SYS_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   // Both ends filter their inputs; the half period must cover that lag
   localparam int SYNC_MARGIN_CYC = 12;
   localparam int HALF_CYC_I = HALF_MIN_CYC > SYNC_MARGIN_CYC ? HALF_MIN_CYC : SYNC_MARGIN_CYC;
   localparam int XFER_TIME_NS = 1000;
   localparam int XFER_CYC_I = (XFER_TIME_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam logic [7:0] LINK_HALF_CYC = 8'(HALF_CYC_I);
   localparam logic [7:0] LINK_XFER_CYC = 8'(XFER_CYC_I);

   // ------------------------------------------------------------
   // Controller register map, byte addresses
   // ------------------------------------------------------------
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_TXDATA = 4'h4;
   localparam logic [3:0] REG_RXDATA = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hC;
   localparam int CTRL_START = 0;
   localparam int CTRL_LONG = 1;
   localparam int STAT_BUSY = 0;
   localparam int STAT_VERR = 1;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_SETUP = 3'b001,
      H_LOW = 3'b010,
      H_HIGH = 3'b011,
      H_HOLD = 3'b100,
      H_GAP = 3'b101
   } qdsc_hstate_t;

endpackage
